/* dv/bwsr_host_model.sv */
// Purpose: host side model issuing register reads and clears
// Assumes: one strobe per call, one cycle wide
// Notes:   answer taken once the registered read data has settled
`timescale 1ns/1ps
`default_nettype none
module bwsr_host_model (
   // clock
   input  wire logic       clk_in,
   // register port of the device
   input  wire logic [7:0] rd_data_in,
   output var  logic       access_out,
   output var  logic       clear_out,
   output var  logic [6:0] addr_out
);
   initial begin
      access_out = 1'b0;
      clear_out  = 1'b0;
      addr_out   = 7'h7f;
   end
   task automatic cmd(input logic [6:0] a, input logic c,
                      output logic [7:0] d);
      @(negedge clk_in);
      addr_out   = a;
      access_out = 1'b1;
      clear_out  = c;
      @(negedge clk_in);
      access_out = 1'b0;
      clear_out  = 1'b0;
      addr_out   = ~a;
      @(negedge clk_in);
      d = rd_data_in;
   endtask
endmodule // bwsr_host_model
`default_nettype wire

/* dv/bwsr_status_regs_tb.sv */
// Purpose: self-checking bench for the status register block
// Assumes: host model makes one strobe per call
// Notes:   all inputs change on the falling clock edge
`timescale 1ns/1ps
`include "bwsr_defs.vh"
`default_nettype none
module bwsr_status_regs_tb;
   localparam logic [6:0] a_dev = `BWSR_ADDR_DEV_INFO;
   localparam logic [6:0] a_bus = `BWSR_ADDR_BUS_COMM;
   localparam logic [6:0] a_wka = `BWSR_ADDR_WAKE_A;
   // stimulus: event pulses, levels and modes
   logic        clk_in;
   logic        rst_in;
   logic [19:0] ev;
   logic [10:0] lv;
   logic [2:0]  sbc_mode;
   logic [2:0]  trx_mode;
   logic [1:0]  fs_src;
   // device and host outputs
   wire logic       access;
   wire logic       clr;
   wire logic [6:0] addr;
   wire logic [7:0] rd_data;
   wire logic       bad_flag;
   wire logic       tx_dis;
   wire logic       sup_en;
   wire logic       irq;
   int miscompares = 0;
   int samples_checked = 0;
   int irq_cnt = 0;
   int cycles = 0;
   int i;
   logic [7:0] fexp [3] = '{8'h02, 8'h04, 8'h06};
   logic [7:0] sexp [3] = '{8'h20, 8'h10, 8'h01};
   bwsr_host_model u_host (.clk_in(clk_in), .rd_data_in(rd_data),
      .access_out(access), .clear_out(clr), .addr_out(addr));
   bwsr_status_regs u_dut (
      .clk_in(clk_in), .rst_in(rst_in), .soft_reset_in(ev[19]),
      .access_in(access), .clear_in(clr), .addr_in(addr),
      .rd_data_out(rd_data), .bad_cmd_flag_out(bad_flag),
      .restart_exit_in(ev[0]), .exit_from_sleep_in(lv[0]),
      .failure_event_in(ev[1]), .sleep_attempt_wake_set_in(ev[2]),
      .fail_output_on_in(ev[3]), .bad_cmd_in(ev[4]), .watchdog_fail_count_in(ev[5]),
      .wd_trigger_ok_in(ev[6]), .sbc_mode_in(sbc_mode),
      .trx_mode_in(trx_mode), .tsd_event_in(ev[7]),
      .tx_dom_timeout_in(ev[8]), .bus_dom_timeout_in(ev[9]),
      .bus_recessive_in(lv[1]), .supply_below_in(lv[2]),
      .bus_silent_flag_in(lv[3]), .silence_timeout_mask_in(lv[4]),
      .swk_cfg_error_in(ev[10]), .frame_err_overflow_in(ev[11]),
      .irq_fall_in(ev[12]), .tx_disable_out(tx_dis),
      .sup_cmp_enable_out(sup_en), .silence_irq_req_out(irq),
      .bus_wake_in(ev[13]), .timer_wake_in(ev[14]),
      .wake_pin_wake_in(ev[15]), .gp_pin_wake_in(ev[16]),
      .failsafe_wake_in(ev[17]), .failsafe_src_in(fs_src),
      .txd_pin_in(lv[5]), .wake_pin_in(lv[6]), .gp_pin_in(lv[7]),
      .test_pin_in(lv[8]), .irq_pullup_config_in(lv[9]),
      .gp_level_enable_in(lv[10]), .sample_strobe_in(ev[18]));
   task automatic summarize;
      if (miscompares == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      logic [7:0] d;
      u_host.cmd(a, 1'b0, d);
      chk("rd_data_out", e, d);
   endtask
   // clear returns the value from before the clear
   task automatic rc(input logic [6:0] a, input logic [7:0] e);
      logic [7:0] d;
      u_host.cmd(a, 1'b1, d);
      chk("rd_data_out on clear", e, d);
   endtask
   task automatic pulse(input int n);
      @(negedge clk_in);
      ev[n] = 1'b1;
      @(negedge clk_in);
      ev[n] = 1'b0;
   endtask
   task automatic wt(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      cycles++;
      if (irq === 1'b1)
         irq_cnt++;
      if (cycles == 20000) begin
         miscompares++;
         summarize();
      end
   end
   initial begin
      ev = '0;
      lv = 11'h023;
      sbc_mode = `BWSR_SBC_NORMAL;
      trx_mode = 3'h2;
      fs_src = 2'h0;
      rst_in = 1'b1;
      wt(3);
      rst_in = 1'b0;
      for (i = 0; i < 6; i++) rd(7'h43 + 7'(i), 8'h00);
      pulse(0);
      rc(a_dev, 8'h80);
      lv[0] = 1'b0;
      pulse(0);
      rc(a_dev, 8'h40);
      pulse(2);
      rc(a_dev, 8'h80);
      pulse(1);
      rc(a_dev, 8'h40);
      lv[9] = 1'b1;
      repeat (3) pulse(5);
      rc(a_dev, 8'h08);
      rd(a_dev, 8'h08);
      pulse(6);
      rd(a_dev, 8'h00);
      lv[9] = 1'b0;
      repeat (2) pulse(5);
      rd(a_dev, 8'h04);
      pulse(6);
      pulse(4);
      wt(20);
      chk("bad_cmd_flag_out", 8'h01, {7'h00, bad_flag});
      rc(a_dev, 8'h02);
      chk("bad_cmd_flag_out", 8'h00, {7'h00, bad_flag});
      pulse(3);
      rc(a_dev, 8'h01);
      for (i = 0; i < 3; i++) begin
         lv[5] = (i != 1);
         lv[1] = (i != 2);
         pulse(7 + i);
         wt(60);
         chk("tx_disable_out", {7'h00, i != 0}, {7'h00, tx_dis});
         lv[5] = 1'b1;
         lv[1] = 1'b1;
         wt(30);
         chk("tx_disable_out", {7'h00, i != 0}, {7'h00, tx_dis});
         wt(20);
         chk("tx_disable_out", 8'h00, {7'h00, tx_dis});
         rc(a_bus, fexp[i]);
      end
      lv[2] = 1'b1;
      wt(4);
      chk("tx_disable_out", 8'h01, {7'h00, tx_dis});
      lv[2] = 1'b0;
      wt(50);
      chk("tx_disable_out", 8'h00, {7'h00, tx_dis});
      rc(a_bus, 8'h01);
      trx_mode = 3'h0;
      lv[2] = 1'b1;
      wt(4);
      chk("sup_cmp_enable_out", 8'h00, {7'h00, sup_en});
      rd(a_bus, 8'h00);
      lv[2] = 1'b0;
      trx_mode = 3'h6;
      sbc_mode = `BWSR_SBC_STOP;
      lv[4] = 1'b1;
      lv[3] = 1'b1;
      wt(3);
      chk("silence irq count", 8'h01, irq_cnt[7:0]);
      lv[3] = 1'b0;
      rc(a_bus, 8'h10);
      rd(a_bus, 8'h10);
      pulse(12);
      rc(a_bus, 8'h10);
      rd(a_bus, 8'h00);
      for (i = 0; i < 4; i++) begin
         lv[4] = i[0];
         sbc_mode = (i == 1) ? `BWSR_SBC_CYCLIC : `BWSR_SBC_NORMAL;
         trx_mode = (i == 2) ? 3'h2 : 3'h6;
         lv[3] = 1'b1;
         wt(3);
         lv[3] = 1'b0;
         pulse(12);
         rc(a_bus, (i == 2) ? 8'h00 : 8'h10);
      end
      chk("silence irq count", 8'h02, irq_cnt[7:0]);
      for (i = 0; i < 3; i++) begin
         trx_mode = (i == 2) ? 3'h2 : 3'h6;
         pulse(10 + (i == 1));
         rc(a_bus, (i == 2) ? 8'h00 : 8'h08);
      end
      pulse(13);
      pulse(14);
      pulse(15);
      rc(a_wka, 8'h31);
      pulse(16);
      rc(`BWSR_ADDR_WAKE_B, 8'h10);
      for (i = 0; i < 3; i++) begin
         fs_src = 2'(i);
         pulse(17);
         rc(a_wka, sexp[i]);
      end
      pulse(13);
      pulse(19);
      rd(a_wka, 8'h00);
      sbc_mode = `BWSR_SBC_RESTART;
      lv[10:6] = 5'h1f;
      wt(4);
      rd(`BWSR_ADDR_LEVEL, 8'hd1);
      sbc_mode = `BWSR_SBC_CYCLIC;
      lv[10:6] = 5'h03;
      wt(4);
      rd(`BWSR_ADDR_LEVEL, 8'hd1);
      pulse(18);
      rd(`BWSR_ADDR_LEVEL, 8'h01);
      sbc_mode = `BWSR_SBC_INIT;
      lv[10:6] = 5'h1c;
      wt(4);
      rd(`BWSR_ADDR_LEVEL, 8'hc0);
      summarize();
   end
endmodule // bwsr_status_regs_tb
`default_nettype wire

/* dv/bwsr_status_sva.sv */
// Purpose: concurrent checks on the status register block ports
// Assumes: single clock domain, synchronous active high reset
// Notes:   bound into every instance of the block
`timescale 1ns/1ps
`include "bwsr_defs.vh"
`default_nettype none
module bwsr_status_sva (
   // clock and reset
   input wire logic       clk_in,
   input wire logic       rst_in,
   input wire logic       soft_reset_in,
   // register port
   input wire logic       access_in,
   input wire logic       clear_in,
   input wire logic [6:0] addr_in,
   input wire logic [7:0] rd_data_out,
   input wire logic       bad_cmd_in,
   input wire logic       bad_cmd_flag_out,
   // transceiver and interrupt
   input wire logic [2:0] sbc_mode_in,
   input wire logic [2:0] trx_mode_in,
   input wire logic       tx_dom_timeout_in,
   input wire logic       supply_below_in,
   input wire logic       txd_pin_in,
   input wire logic       bus_silent_flag_in,
   input wire logic       silence_timeout_mask_in,
   input wire logic       tx_disable_out,
   input wire logic       sup_cmp_enable_out,
   input wire logic       silence_irq_req_out
);
   logic [7:0] rsv_mask;
   logic [5:0] txd_hi_q;
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // reserved bit positions of the addressed register
   always_comb begin
      case (addr_in)
         `BWSR_ADDR_DEV_INFO: rsv_mask = 8'h30;
         `BWSR_ADDR_BUS_COMM: rsv_mask = 8'he0;
         `BWSR_ADDR_WAKE_A:   rsv_mask = 8'hce;
         `BWSR_ADDR_WAKE_B:   rsv_mask = 8'hef;
         `BWSR_ADDR_LEVEL:    rsv_mask = 8'h2e;
         default:             rsv_mask = 8'hff;
      endcase
   end
   // unbroken high cycles of the transmit input
   always_ff @(posedge clk_in) begin
      if (rst_in || !txd_pin_in)
         txd_hi_q <= 6'h00;
      else if (txd_hi_q != 6'h3f)
         txd_hi_q <= txd_hi_q + 6'h01;
   end
   chk_reserved_zero: assert property (access_in |=>
      (rd_data_out & $past(rsv_mask)) == 8'h00)
      else $error("reserved read data bit set");
   chk_cmp_follows: assert property (
      sup_cmp_enable_out == trx_mode_in[1])
      else $error("comparator enable differs from mode bit");
   chk_uv_tx_off: assert property (disable iff (rst_in || soft_reset_in)
      supply_below_in && trx_mode_in[1] |-> ##[1:3] tx_disable_out)
      else $error("transmitter left on under supply low");
   chk_txdom_off: assert property (disable iff (rst_in || soft_reset_in)
      tx_dom_timeout_in |=> tx_disable_out)
      else $error("transmitter left on after timeout");
   chk_tx_enable_wait: assert property (
      $fell(tx_disable_out) && !$past(soft_reset_in) && !$past(rst_in)
      |-> txd_hi_q >= 6'd40)
      else $error("transmitter enabled too early");
   chk_silence_irq: assert property (
      $rose(bus_silent_flag_in) && trx_mode_in[2] && silence_timeout_mask_in
      && (sbc_mode_in == `BWSR_SBC_NORMAL || sbc_mode_in == `BWSR_SBC_STOP)
      |=> silence_irq_req_out)
      else $error("silence interrupt missing");
   chk_irq_cause: assert property (
      silence_irq_req_out |-> $past(trx_mode_in) >= 3'h4
      && $past(silence_timeout_mask_in))
      else $error("silence interrupt without cause");
   chk_bad_cmd_set: assert property (bad_cmd_in |=> bad_cmd_flag_out)
      else $error("bad command flag not set");
   chk_bad_cmd_hold: assert property (disable iff (rst_in || soft_reset_in)
      bad_cmd_flag_out && !(clear_in && addr_in == `BWSR_ADDR_DEV_INFO)
      |=> bad_cmd_flag_out)
      else $error("bad command flag dropped");
endmodule // bwsr_status_sva
bind bwsr_status_regs bwsr_status_sva u_sva (
   .clk_in(clk_in), .rst_in(rst_in), .soft_reset_in(soft_reset_in),
   .access_in(access_in), .clear_in(clear_in), .addr_in(addr_in),
   .rd_data_out(rd_data_out), .bad_cmd_in(bad_cmd_in),
   .bad_cmd_flag_out(bad_cmd_flag_out), .sbc_mode_in(sbc_mode_in),
   .trx_mode_in(trx_mode_in), .tx_dom_timeout_in(tx_dom_timeout_in),
   .supply_below_in(supply_below_in), .txd_pin_in(txd_pin_in),
   .bus_silent_flag_in(bus_silent_flag_in),
   .silence_timeout_mask_in(silence_timeout_mask_in),
   .tx_disable_out(tx_disable_out), .sup_cmp_enable_out(sup_cmp_enable_out),
   .silence_irq_req_out(silence_irq_req_out)
);
`default_nettype wire

/* hw/bwsr_defs.vh */
// Purpose: constants for the bus and wake status register slice
// Assumes: 10 MHz clock, seven bit register addresses
// Notes:   offsets are register addresses on the serial command port
`ifndef BWSR_DEFS_VH
`define BWSR_DEFS_VH

// register addresses
`define BWSR_ADDR_DEV_INFO    7'h43
`define BWSR_ADDR_BUS_COMM    7'h44
`define BWSR_ADDR_WAKE_A      7'h46
`define BWSR_ADDR_WAKE_B      7'h47
`define BWSR_ADDR_LEVEL       7'h48

// reset values
`define BWSR_RST_BYTE         8'h00

// device info fields
`define BWSR_PRS_HI           7
`define BWSR_PRS_LO           6
`define BWSR_WDF_HI           3
`define BWSR_WDF_LO           2
`define BWSR_BAD_CMD_BIT      1
`define BWSR_FAILURE_BIT      0
`define BWSR_PRS_CLEARED      2'h0
`define BWSR_PRS_FAILURE      2'h1
`define BWSR_PRS_SLEEP        2'h2
`define BWSR_WDF_MAX          2'h2

// bus comm fields
`define BWSR_SIL_TO_BIT       4
`define BWSR_SW_ERR_BIT       3
`define BWSR_FAULT_HI         2
`define BWSR_FAULT_LO         1
`define BWSR_SUP_LOW_BIT      0
`define BWSR_FLT_NONE         2'h0
`define BWSR_FLT_THERMAL      2'h1
`define BWSR_FLT_TX_DOM       2'h2
`define BWSR_FLT_BUS_DOM      2'h3

// wake fields
`define BWSR_BUS_WU_BIT       5
`define BWSR_TIMER_WAKE_FLAG_BIT     4
`define BWSR_WAKE_PIN_FLAG_BIT        0
`define BWSR_GP_WU_BIT        4

// level fields
`define BWSR_TEST_MODE_BIT    7
`define BWSR_PULLUP_BIT       6
`define BWSR_GP_LVL_BIT       4
`define BWSR_WAKE_PIN_LEVEL_BIT       0

// transceiver mode bits
`define BWSR_MODE_ACTIVE_BIT  1
`define BWSR_MODE_SWK_BIT     2

// device operating modes (one code per mode)
`define BWSR_SBC_INIT         3'h0
`define BWSR_SBC_NORMAL       3'h1
`define BWSR_SBC_STOP         3'h2
`define BWSR_SBC_RESTART      3'h3
`define BWSR_SBC_CYCLIC       3'h4
`define BWSR_SBC_OTHER        3'h5

// fail-safe wake sources
`define BWSR_SRC_BUS          2'h0
`define BWSR_SRC_TIMER        2'h1
`define BWSR_SRC_PIN          2'h2

// transmitter enable time
`define BWSR_TX_EN_TIME_NS    4000
`define BWSR_CLK_PERIOD_NS    100
`define BWSR_TX_EN_CYCLES     ((`BWSR_TX_EN_TIME_NS + `BWSR_CLK_PERIOD_NS - 1) / `BWSR_CLK_PERIOD_NS)

`endif

/* hw/bwsr_status_regs.v */
// Purpose: bus, wake and level status registers of the basis chip
// Assumes: command decoder on the same clock presents access strobes
// Notes:   pin levels pass a two flop synchroniser before use
//
// Summary of operation
// - pre-restart state records sleep exit or failure exit from restart.
// - sleep attempt with wake flags still set records sleep as pre-state.
// - watchdog fail bits count and are self-cleared by the device.
// - bad command flag clears only by an explicit clear command.
// - configs 2/4 freeze watchdog count after failure until good trigger.
// - fault code bits 2:1: none, thermal, tx dominant, bus dominant.
// - bus supply undervoltage sets bit 0 and disables the transmitter.
// - tx dominant recovers on tx high, wake-capable or off mode.
// - bus dominant recovers on recessive bus, wake-capable or off mode.
// - supply undervoltage recovers when supply rises above threshold.
// - after any fault, tx must stay high for enable time first.
// - undervoltage comparator active only while mode bit 1 is one.
// - silence timeout sets on silent flag with selective wake; sticky.
// - silence timeout raises interrupt in stop/normal when mask is one.
// - selective wake error on config error or overflow; swk only.
// - silence timeout clear blocked until next interrupt falling edge.
// - wake from fail-safe also sets the responsible source flag.
// - general purpose pin wake sets gp wake flag bit 4.
// - level bit 7 shows test pin mode: user or development.
// - level bit 6 shows interrupt pull-up detected (configs 1/3).
// - level bit 4 shows gp pin level, bit 0 wake pin level.
// - level register updates in active modes and after each sample.
`timescale 1ns/1ps
`include "bwsr_defs.vh"
`default_nettype none

module bwsr_status_regs (
   // clock and reset
   input  wire       clk_in,
   input  wire       rst_in,
   input  wire       soft_reset_in,
   // register access from the command decoder
   input  wire       access_in,
   input  wire       clear_in,
   input  wire [6:0] addr_in,
   output wire [7:0] rd_data_out,
   output wire       bad_cmd_flag_out,
   // device state events
   input  wire       restart_exit_in,
   input  wire       exit_from_sleep_in,
   input  wire       failure_event_in,
   input  wire       sleep_attempt_wake_set_in,
   input  wire       fail_output_on_in,
   input  wire       bad_cmd_in,
   input  wire       watchdog_fail_count_in,
   input  wire       wd_trigger_ok_in,
   input  wire [2:0] sbc_mode_in,
   // transceiver
   input  wire [2:0] trx_mode_in,
   input  wire       tsd_event_in,
   input  wire       tx_dom_timeout_in,
   input  wire       bus_dom_timeout_in,
   input  wire       bus_recessive_in,
   input  wire       supply_below_in,
   input  wire       bus_silent_flag_in,
   input  wire       silence_timeout_mask_in,
   input  wire       swk_cfg_error_in,
   input  wire       frame_err_overflow_in,
   input  wire       irq_fall_in,
   output wire       tx_disable_out,
   output wire       sup_cmp_enable_out,
   output wire       silence_irq_req_out,
   // wake sources
   input  wire       bus_wake_in,
   input  wire       timer_wake_in,
   input  wire       wake_pin_wake_in,
   input  wire       gp_pin_wake_in,
   input  wire       failsafe_wake_in,
   input  wire [1:0] failsafe_src_in,
   // levels
   input  wire       txd_pin_in,
   input  wire       wake_pin_in,
   input  wire       gp_pin_in,
   input  wire       test_pin_in,
   input  wire       irq_pullup_config_in,
   input  wire       gp_level_enable_in,
   input  wire       sample_strobe_in
);

   localparam [31:0] TX_EN_FULL = `BWSR_TX_EN_CYCLES;
   localparam [6:0] TX_EN_CNT = TX_EN_FULL[6:0];
   localparam [2:0] TX_ON     = 3'b001;
   localparam [2:0] TX_FAULT  = 3'b010;
   localparam [2:0] TX_WAIT   = 3'b100;

   function clr_hit;
      input       clr;
      input [6:0] a;
      input [6:0] target;
      begin
         clr_hit = clr & (a == target);
      end
   endfunction

   // pin synchronisers
   reg  [3:0] pin_s1_q;
   reg  [3:0] pin_s2_q;
   wire       txd_high = pin_s2_q[0];

   always @(posedge clk_in) begin
      if (rst_in) begin
         pin_s1_q <= 4'h0;
         pin_s2_q <= 4'h0;
      end else begin
         pin_s1_q <= {test_pin_in, gp_pin_in, wake_pin_in, txd_pin_in};
         pin_s2_q <= pin_s1_q;
      end
   end

   // register state
   reg  [1:0] prs_q;
   reg  [1:0] wdf_q;
   reg        wd_frozen_q;
   reg        bad_cmd_q;
   reg        failure_q;
   reg  [1:0] fault_q;
   reg        sup_low_q;
   reg        sw_err_q;
   reg        sil_to_q;
   reg        sil_block_q;
   reg        silent_prev_q;
   reg        bus_wu_q;
   reg        timer_wake_flag_q;
   reg        wake_pin_flag_q;
   reg        gp_wu_q;
   reg  [7:0] level_q;
   reg  [7:0] rd_data_q;
   reg        tx_dom_act_q;
   reg        bus_dom_act_q;
   reg        tsd_act_q;
   reg  [2:0] tx_state_q;
   reg  [6:0] tx_cnt_q;
   reg        sil_irq_q;

   wire clr_dev  = clr_hit(clear_in, addr_in, `BWSR_ADDR_DEV_INFO);
   wire clr_bus  = clr_hit(clear_in, addr_in, `BWSR_ADDR_BUS_COMM);
   wire clr_wk_a = clr_hit(clear_in, addr_in, `BWSR_ADDR_WAKE_A);
   wire clr_wk_b = clr_hit(clear_in, addr_in, `BWSR_ADDR_WAKE_B);

   wire trx_active = trx_mode_in[`BWSR_MODE_ACTIVE_BIT];
   wire swk_on     = trx_mode_in[`BWSR_MODE_SWK_BIT];
   wire sup_cmp_on = trx_active;
   wire sup_fault  = sup_cmp_on & supply_below_in;
   wire sil_rise   = bus_silent_flag_in & ~silent_prev_q;
   wire sil_set    = swk_on & sil_rise;
   wire irq_mode   = (sbc_mode_in == `BWSR_SBC_NORMAL) |
                     (sbc_mode_in == `BWSR_SBC_STOP);
   wire lvl_mode   = irq_mode | (sbc_mode_in == `BWSR_SBC_INIT) |
                     (sbc_mode_in == `BWSR_SBC_RESTART);
   wire lvl_upd    = lvl_mode | sample_strobe_in;
   wire fs_bus     = failsafe_wake_in &
                     (failsafe_src_in == `BWSR_SRC_BUS);
   wire fs_timer   = failsafe_wake_in &
                     (failsafe_src_in == `BWSR_SRC_TIMER);
   wire fs_pin     = failsafe_wake_in &
                     (failsafe_src_in == `BWSR_SRC_PIN);
   wire any_fault  = tsd_act_q | tx_dom_act_q | bus_dom_act_q | sup_fault;

   // device info: pre-restart state, watchdog count, command flags
   always @(posedge clk_in) begin
      if (rst_in | soft_reset_in) begin
         prs_q       <= `BWSR_PRS_CLEARED;
         wdf_q       <= 2'h0;
         wd_frozen_q <= 1'b0;
         bad_cmd_q   <= 1'b0;
         failure_q   <= 1'b0;
      end else begin
         if (sleep_attempt_wake_set_in)
            prs_q <= `BWSR_PRS_SLEEP;
         else if (failure_event_in)
            prs_q <= `BWSR_PRS_FAILURE;
         else if (restart_exit_in)
            prs_q <= exit_from_sleep_in ? `BWSR_PRS_SLEEP :
                                          `BWSR_PRS_FAILURE;
         else if (clr_dev)
            prs_q <= `BWSR_PRS_CLEARED;
         if (wd_trigger_ok_in) begin
            wdf_q       <= 2'h0;
            wd_frozen_q <= 1'b0;
         end else if (watchdog_fail_count_in & ~wd_frozen_q) begin
            if (wdf_q != `BWSR_WDF_MAX)
               wdf_q <= wdf_q + 2'h1;
            wd_frozen_q <= ~irq_pullup_config_in;
         end
         if (bad_cmd_in)
            bad_cmd_q <= 1'b1;
         else if (clr_dev)
            bad_cmd_q <= 1'b0;
         if (fail_output_on_in)
            failure_q <= 1'b1;
         else if (clr_dev)
            failure_q <= 1'b0;
      end
   end

   // bus comm status flags
   always @(posedge clk_in) begin
      if (rst_in | soft_reset_in) begin
         fault_q       <= `BWSR_FLT_NONE;
         sup_low_q     <= 1'b0;
         sw_err_q      <= 1'b0;
         sil_to_q      <= 1'b0;
         sil_block_q   <= 1'b0;
         silent_prev_q <= 1'b0;
         sil_irq_q     <= 1'b0;
      end else begin
         silent_prev_q <= bus_silent_flag_in;
         if (bus_dom_timeout_in)
            fault_q <= `BWSR_FLT_BUS_DOM;
         else if (tx_dom_timeout_in)
            fault_q <= `BWSR_FLT_TX_DOM;
         else if (tsd_event_in)
            fault_q <= `BWSR_FLT_THERMAL;
         else if (clr_bus)
            fault_q <= `BWSR_FLT_NONE;
         if (sup_fault)
            sup_low_q <= 1'b1;
         else if (clr_bus)
            sup_low_q <= 1'b0;
         if (swk_on & (swk_cfg_error_in | frame_err_overflow_in))
            sw_err_q <= 1'b1;
         else if (clr_bus)
            sw_err_q <= 1'b0;
         if (sil_set) begin
            sil_to_q    <= 1'b1;
            sil_block_q <= 1'b1;
         end else begin
            if (irq_fall_in)
               sil_block_q <= 1'b0;
            if (clr_bus & ~sil_block_q)
               sil_to_q <= 1'b0;
         end
         sil_irq_q <= sil_set & irq_mode & silence_timeout_mask_in;
      end
   end

   // transceiver fault tracking and transmitter release
   always @(posedge clk_in) begin
      if (rst_in | soft_reset_in) begin
         tx_dom_act_q  <= 1'b0;
         bus_dom_act_q <= 1'b0;
         tsd_act_q     <= 1'b0;
         tx_state_q    <= TX_ON;
         tx_cnt_q      <= 7'h00;
      end else begin
         if (tx_dom_timeout_in)
            tx_dom_act_q <= 1'b1;
         else if (txd_high | ~trx_active)
            tx_dom_act_q <= 1'b0;
         if (bus_dom_timeout_in)
            bus_dom_act_q <= 1'b1;
         else if (bus_recessive_in | ~trx_active)
            bus_dom_act_q <= 1'b0;
         if (tsd_event_in)
            tsd_act_q <= 1'b1;
         else
            tsd_act_q <= 1'b0;
         case (tx_state_q)
            TX_ON: begin
               if (any_fault | tsd_event_in | tx_dom_timeout_in |
                   bus_dom_timeout_in)
                  tx_state_q <= TX_FAULT;
            end
            TX_FAULT: begin
               tx_cnt_q <= 7'h00;
               if (~any_fault)
                  tx_state_q <= TX_WAIT;
            end
            TX_WAIT: begin
               if (any_fault) begin
                  tx_state_q <= TX_FAULT;
               end else if (~txd_high) begin
                  tx_cnt_q <= 7'h00;
               end else if (tx_cnt_q == TX_EN_CNT - 7'h01) begin
                  tx_state_q <= TX_ON;
               end else begin
                  tx_cnt_q <= tx_cnt_q + 7'h01;
               end
            end
            default: begin
               tx_state_q <= TX_FAULT;
            end
         endcase
      end
   end

   // wake source flags
   always @(posedge clk_in) begin
      if (rst_in | soft_reset_in) begin
         bus_wu_q   <= 1'b0;
         timer_wake_flag_q <= 1'b0;
         wake_pin_flag_q    <= 1'b0;
         gp_wu_q    <= 1'b0;
      end else begin
         if (bus_wake_in | fs_bus)
            bus_wu_q <= 1'b1;
         else if (clr_wk_a)
            bus_wu_q <= 1'b0;
         if (timer_wake_in | fs_timer)
            timer_wake_flag_q <= 1'b1;
         else if (clr_wk_a)
            timer_wake_flag_q <= 1'b0;
         if (wake_pin_wake_in | fs_pin)
            wake_pin_flag_q <= 1'b1;
         else if (clr_wk_a)
            wake_pin_flag_q <= 1'b0;
         if (gp_pin_wake_in)
            gp_wu_q <= 1'b1;
         else if (clr_wk_b)
            gp_wu_q <= 1'b0;
      end
   end

   // level register
   always @(posedge clk_in) begin
      if (rst_in | soft_reset_in) begin
         level_q <= `BWSR_RST_BYTE;
      end else if (lvl_upd) begin
         level_q                       <= 8'h00;
         level_q[`BWSR_TEST_MODE_BIT]  <= pin_s2_q[3];
         level_q[`BWSR_PULLUP_BIT]     <= irq_pullup_config_in;
         level_q[`BWSR_GP_LVL_BIT]     <= gp_level_enable_in &
                                          pin_s2_q[2];
         level_q[`BWSR_WAKE_PIN_LEVEL_BIT]     <= pin_s2_q[1];
      end
   end

   // read data, reserved bits zero
   reg [7:0] rd_mux;

   always @* begin
      rd_mux = 8'h00;
      case (addr_in)
         `BWSR_ADDR_DEV_INFO: begin
            rd_mux[`BWSR_PRS_HI:`BWSR_PRS_LO] = prs_q;
            rd_mux[`BWSR_WDF_HI:`BWSR_WDF_LO] = wdf_q;
            rd_mux[`BWSR_BAD_CMD_BIT]         = bad_cmd_q;
            rd_mux[`BWSR_FAILURE_BIT]         = failure_q;
         end
         `BWSR_ADDR_BUS_COMM: begin
            rd_mux[`BWSR_SIL_TO_BIT]              = sil_to_q;
            rd_mux[`BWSR_SW_ERR_BIT]              = sw_err_q;
            rd_mux[`BWSR_FAULT_HI:`BWSR_FAULT_LO] = fault_q;
            rd_mux[`BWSR_SUP_LOW_BIT]             = sup_low_q;
         end
         `BWSR_ADDR_WAKE_A: begin
            rd_mux[`BWSR_BUS_WU_BIT]   = bus_wu_q;
            rd_mux[`BWSR_TIMER_WAKE_FLAG_BIT] = timer_wake_flag_q;
            rd_mux[`BWSR_WAKE_PIN_FLAG_BIT]    = wake_pin_flag_q;
         end
         `BWSR_ADDR_WAKE_B: begin
            rd_mux[`BWSR_GP_WU_BIT] = gp_wu_q;
         end
         `BWSR_ADDR_LEVEL: begin
            rd_mux = level_q;
         end
         default: begin
            rd_mux = 8'h00;
         end
      endcase
   end

   always @(posedge clk_in) begin
      if (rst_in)
         rd_data_q <= 8'h00;
      else if (access_in)
         rd_data_q <= rd_mux;
   end

   assign rd_data_out         = rd_data_q;
   assign bad_cmd_flag_out    = bad_cmd_q;
   assign tx_disable_out      = (tx_state_q != TX_ON);
   assign sup_cmp_enable_out  = sup_cmp_on;
   assign silence_irq_req_out = sil_irq_q;

endmodule // bwsr_status_regs

`default_nettype wire
